//--- ccb_pkg.sv
// Constants and types shared by the challenge-count blinker block
// Assumes a single 20 MHz clock and an active-low asynchronous reset

package ccb_pkg;

   // =========================================================
   // Clock and timing
   // =========================================================
   // System clock rate in hertz
   localparam int unsigned CLK_HZ         = 32'h0131_2D00;
   // Cycles per millisecond
   localparam int unsigned CYC_PER_MS     = CLK_HZ / 32'h0000_03E8;
   // Longest window for three counts, in milliseconds
   localparam int unsigned WINDOW_TIME_MS = 32'h0000_2EE0;
   // Blinker flash length, in milliseconds
   localparam int unsigned FLASH_TIME_MS  = 32'h0000_03E8;
   // Window length in cycles, rounded down
   localparam int unsigned WINDOW_CYCLES  = WINDOW_TIME_MS * CYC_PER_MS;
   // Flash length in cycles, rounded down
   localparam int unsigned FLASH_CYCLES   = FLASH_TIME_MS * CYC_PER_MS;

   // =========================================================
   // Blink counter states and clearout causes
   // =========================================================
   // Four states of the scale-of-three counter
   typedef enum logic [1:0] {
      CCB_ST_1,
      CCB_ST_2,
      CCB_ST_3,
      CCB_ST_4
   } ccb_count_t;

   // Source of the most recent clearout
   typedef enum logic [1:0] {
      CCB_CAUSE_NONE,
      CCB_CAUSE_TX,
      CCB_CAUSE_FLASH,
      CCB_CAUSE_WINDOW
   } ccb_cause_t;

   // =========================================================
   // Values after reset
   // =========================================================
   localparam ccb_count_t RST_COUNT    = CCB_ST_1;
   localparam ccb_cause_t RST_CAUSE    = CCB_CAUSE_NONE;
   localparam logic       RST_WINDOW   = 1'h0;
   localparam logic       RST_LIGHT    = 1'h0;
   localparam logic       RST_CLEAROUT = 1'h0;
   localparam logic       RST_FIRE     = 1'h0;

endpackage

//--- ccb_cycle_timer.sv
// Cycle-counting delay timer used for the window and flash delays
// Assumes run and discharge come from logic on the same clock

`timescale 1ns/100ps

module ccb_cycle_timer #(
   parameter int unsigned TERM = 10            // Cycles of run before firing
) (
   input  wire logic clk,                      // System clock
   input  wire logic rst_b,                    // Asynchronous reset, active low
   input  wire logic run,                      // Accumulate while high
   input  wire logic discharge,                // Clear accumulated delay
   output logic      fire                      // One-cycle expiry pulse
);

   localparam int unsigned W = (TERM < 2) ? 2 : $clog2(TERM + 1);

   // =========================================================
   // State
   // =========================================================
   typedef struct packed {
      logic [W-1:0] count;
      logic         fire;
   } ccb_tmr_state_t;

   ccb_tmr_state_t st_r;
   ccb_tmr_state_t st_nxt;

   // Accumulate, fire once at terminal count, then hold
   always_comb begin
      st_nxt      = st_r;
      st_nxt.fire = ccb_pkg::RST_FIRE;
      if (discharge) begin
         st_nxt.count = '0;
      end else if (run && (st_r.count < W'(TERM))) begin
         st_nxt.count = st_r.count + W'(1);
         if (st_r.count == W'(TERM - 1)) begin
            st_nxt.fire = 1'h1;
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r.count <= '0;
         st_r.fire  <= ccb_pkg::RST_FIRE;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign fire = st_r.fire;

endmodule

//--- ccb_blinker.sv
// Standby blinker controller: counts correct received challenges
// Assumes all inputs come from recognizer and keying logic on clk

`timescale 1ns/100ps

module ccb_blinker #(
   parameter int unsigned WINDOW_CYCLES = ccb_pkg::WINDOW_CYCLES, // Window length
   parameter int unsigned FLASH_CYCLES  = ccb_pkg::FLASH_CYCLES   // Flash length
) (
   input  wire logic       clk,                       // System clock, 20 MHz
   input  wire logic       rst_b,                     // Asynchronous reset, active low
   input  wire logic       standby,                   // Unit on standby, level
   input  wire logic       correct_challenge_trigger, // Correct challenge received, pulse
   input  wire logic       challenge_keying_delay,    // Own challenge transmitted, pulse
   output logic            blinker_light,             // Blinker light drive, level
   output logic            window_switch,             // Window switch state, level
   output logic [1:0]      blink_state,               // Counter state, 0 means state 1
   output logic            flash_running,             // Flash timer powered, level
   output logic            clearout_pulse,            // Clearout pulse, one cycle
   output logic [1:0]      clearout_cause             // Source of last clearout
);

   // =========================================================
   // State of the block
   // =========================================================
   typedef struct packed {
      ccb_pkg::ccb_count_t count;     // Blink counter stages
      logic                window;    // Window switch
      logic                light;     // Blinker drivers enabled
      logic                flash_on;  // Flash timer powered
      logic                clearout;  // Clearout driver pulse
      ccb_pkg::ccb_cause_t cause;     // Last clearout source
   } ccb_state_t;

   ccb_state_t st_r;
   ccb_state_t st_nxt;

   // =========================================================
   // Internal nets
   // =========================================================
   logic flash_fire;        // Flash timer expiry
   logic window_fire;       // Window timer expiry
   logic flash_power;       // Flash timer supply
   logic flash_discharge;   // Flash timer reset
   logic window_run;        // Window timer supply
   logic window_discharge;  // Window timer reset
   logic flash_expired;     // Flash expiry while still lit
   logic window_expired;    // Window expiry while switch set
   logic clear_req;         // Any clearout source
   logic count_evt;         // Counted correct challenge

   // =========================================================
   // Helper functions
   // =========================================================
   // Next counter state for one correct challenge
   function automatic ccb_pkg::ccb_count_t next_count(input ccb_pkg::ccb_count_t cur);
      ccb_pkg::ccb_count_t res;
      res = cur;
      unique case (cur)
         ccb_pkg::CCB_ST_1: res = ccb_pkg::CCB_ST_2;
         ccb_pkg::CCB_ST_2: res = ccb_pkg::CCB_ST_3;
         ccb_pkg::CCB_ST_3: res = ccb_pkg::CCB_ST_4;
         ccb_pkg::CCB_ST_4: res = ccb_pkg::CCB_ST_4;
      endcase
      return res;
   endfunction

   // True when a counter state sits in the final, lit state
   function automatic logic is_final(input ccb_pkg::ccb_count_t cur);
      return (cur == ccb_pkg::CCB_ST_4);
   endfunction

   // =========================================================
   // Timer supplies
   // =========================================================
   // Flash timer powered only in state 4, from the lit edge
   assign flash_power      = is_final(st_r.count);
   assign flash_discharge  = !is_final(st_r.count);
   // Window timer runs while the switch is set
   assign window_run       = st_r.window;
   // Delay discharged only once the switch has been cleared
   assign window_discharge = !st_r.window;

   // =========================================================
   // Delay timers
   // =========================================================
   // Slow window timer
   ccb_cycle_timer #(
      .TERM      (WINDOW_CYCLES)
   ) u_slow_window_timer (
      .clk       (clk),
      .rst_b     (rst_b),
      .run       (window_run),
      .discharge (window_discharge),
      .fire      (window_fire)
   );

   // Flash timer
   ccb_cycle_timer #(
      .TERM      (FLASH_CYCLES)
   ) u_flash_timer (
      .clk       (clk),
      .rst_b     (rst_b),
      .run       (flash_power),
      .discharge (flash_discharge),
      .fire      (flash_fire)
   );

   // =========================================================
   // Clearout sources
   // =========================================================
   // Any of the three sources fires the clearout driver
   // A fire registered on the edge of another clearout is stale; mask it
   assign flash_expired  = flash_fire & flash_power;
   assign window_expired = window_fire & window_run;
   assign clear_req = challenge_keying_delay | flash_expired | window_expired;
   // Correct challenges count only on standby
   assign count_evt = standby & correct_challenge_trigger;

   // =========================================================
   // Next state
   // =========================================================
   // Counter, window switch, light and clearout driver
   always_comb begin
      st_nxt          = st_r;
      st_nxt.clearout = ccb_pkg::RST_CLEAROUT;
      if (clear_req) begin
         // One pulse resets both stages and the switch at once
         st_nxt.clearout = 1'h1;
         st_nxt.count    = ccb_pkg::CCB_ST_1;
         st_nxt.window   = ccb_pkg::RST_WINDOW;
         st_nxt.light    = ccb_pkg::RST_LIGHT;
         st_nxt.flash_on = 1'h0;
         // Own transmission has the highest priority
         if (challenge_keying_delay) begin
            st_nxt.cause = ccb_pkg::CCB_CAUSE_TX;
         end else if (flash_expired) begin
            st_nxt.cause = ccb_pkg::CCB_CAUSE_FLASH;
         end else begin
            st_nxt.cause = ccb_pkg::CCB_CAUSE_WINDOW;
         end
      end else if (count_evt && !is_final(st_r.count)) begin
         st_nxt.count  = next_count(st_r.count);
         // Switch trips once on any advance and then holds
         st_nxt.window = 1'h1;
         // Third transition lights the blinker and powers the flash timer
         if (st_r.count == ccb_pkg::CCB_ST_3) begin
            st_nxt.light    = 1'h1;
            st_nxt.flash_on = 1'h1;
         end
      end
   end

   // =========================================================
   // State register
   // =========================================================
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r.count    <= ccb_pkg::RST_COUNT;
         st_r.window   <= ccb_pkg::RST_WINDOW;
         st_r.light    <= ccb_pkg::RST_LIGHT;
         st_r.flash_on <= ccb_pkg::RST_LIGHT;
         st_r.clearout <= ccb_pkg::RST_CLEAROUT;
         st_r.cause    <= ccb_pkg::RST_CAUSE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // =========================================================
   // Outputs, all straight from the state register
   // =========================================================
   assign blinker_light  = st_r.light;
   assign window_switch  = st_r.window;
   assign blink_state    = st_r.count;
   assign flash_running  = st_r.flash_on;
   assign clearout_pulse = st_r.clearout;
   assign clearout_cause = st_r.cause;

endmodule

//--- ccb_monitor.sv
// Concurrent checks on the ports of the challenge-count blinker
// Assumes one clock domain and the shortened timer parameters of the top
`timescale 1ns/100ps

module ccb_monitor #(
   parameter int unsigned WINDOW_CYCLES = 40,     // Window length
   parameter int unsigned FLASH_CYCLES  = 5       // Flash length
) (
   input wire logic       clk,                       // System clock
   input wire logic       rst_b,                     // Reset, active low
   input wire logic       standby,                   // Standby level
   input wire logic       correct_challenge_trigger, // Count pulse
   input wire logic       challenge_keying_delay,    // Own challenge pulse
   input wire logic       blinker_light,             // Light drive
   input wire logic       window_switch,             // Window switch
   input wire logic [1:0] blink_state,               // Counter state
   input wire logic       flash_running,             // Flash timer power
   input wire logic       clearout_pulse,            // Clearout pulse
   input wire logic [1:0] clearout_cause             // Last clearout source
);
   int unsigned lt_cnt_r;                            // Cycles light on
   int unsigned win_cnt_r;                           // Cycles window set
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // ==========================================
   // Helper counters for the two delays
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lt_cnt_r  <= 0;
         win_cnt_r <= 0;
      end else begin
         lt_cnt_r  <= blinker_light ? lt_cnt_r + 1 : 0;
         win_cnt_r <= window_switch ? win_cnt_r + 1 : 0;
      end
   end
   // ==========================================
   // Assertions
   a_tx_clears: assert property (
      challenge_keying_delay |=> clearout_pulse && blink_state == 2'h0
         && clearout_cause == ccb_pkg::CCB_CAUSE_TX)
      else $error("own challenge did not clear");
   a_count_adv: assert property (
      correct_challenge_trigger && standby && !challenge_keying_delay
         && blink_state != 2'h3
      |=> clearout_pulse || blink_state == $past(blink_state) + 2'h1)
      else $error("counter did not advance");
   a_window_set: assert property (blink_state != 2'h0 |-> window_switch)
      else $error("window switch not set");
   a_window_hold: assert property (window_switch |=> window_switch || clearout_pulse)
      else $error("window switch dropped early");
   a_light_state: assert property (blinker_light == (blink_state == 2'h3))
      else $error("light not tied to state 4");
   a_flash_power: assert property (flash_running == (blink_state == 2'h3))
      else $error("flash power outside state 4");
   a_clear_all: assert property (
      clearout_pulse |-> blink_state == 2'h0 && !window_switch && !blinker_light)
      else $error("clearout left state");
   a_flash_len: assert property (
      clearout_pulse && clearout_cause == ccb_pkg::CCB_CAUSE_FLASH
      |-> lt_cnt_r == FLASH_CYCLES + 1)
      else $error("flash length wrong");
   a_window_len: assert property (
      clearout_pulse && clearout_cause == ccb_pkg::CCB_CAUSE_WINDOW
      |-> win_cnt_r == WINDOW_CYCLES + 1)
      else $error("window length wrong");
   a_standby_gate: assert property (
      !standby |=> clearout_pulse || blink_state == $past(blink_state))
      else $error("counted off standby");
   // Main scenarios reached
   c_lit: cover property ($rose(blinker_light));
   c_tx: cover property (clearout_pulse && clearout_cause == ccb_pkg::CCB_CAUSE_TX);
   c_flash: cover property (clearout_pulse && clearout_cause == ccb_pkg::CCB_CAUSE_FLASH);
   c_window: cover property (clearout_pulse && clearout_cause == ccb_pkg::CCB_CAUSE_WINDOW);
endmodule

bind ccb_blinker ccb_monitor #(.WINDOW_CYCLES(WINDOW_CYCLES), .FLASH_CYCLES(FLASH_CYCLES)) u_mon (
   .clk(clk), .rst_b(rst_b), .standby(standby),
   .correct_challenge_trigger(correct_challenge_trigger),
   .challenge_keying_delay(challenge_keying_delay), .blinker_light(blinker_light),
   .window_switch(window_switch), .blink_state(blink_state), .flash_running(flash_running),
   .clearout_pulse(clearout_pulse), .clearout_cause(clearout_cause));

//--- ccb_partner.sv
// Model of the challenge recognizer and the keying path
// Assumes the bench calls its tasks; outputs change just after clk rises
`timescale 1ns/100ps

module ccb_partner (
   input  wire logic clk,                         // System clock
   output logic      trig,                        // Correct challenge pulse
   output logic      key                          // Own challenge pulse
);
   initial begin
      trig = 1'h0;
      key  = 1'h0;
   end
   // Correct challenges on successive cycles, exact counts only
   task automatic rx(input int n);
      repeat (n) begin
         @(posedge clk);
         trig <= 1'h1;
      end
      @(posedge clk);
      trig <= 1'h0;
   endtask
   // Own challenge, optionally with a received one in the same cycle
   task automatic tx(input logic with_rx);
      @(posedge clk);
      key  <= 1'h1;
      trig <= with_rx;
      @(posedge clk);
      key  <= 1'h0;
      trig <= 1'h0;
   endtask
endmodule

//--- test_challenge_count_blinker.sv
// Self-checking bench for the challenge-count blinker
// Assumes the partner model drives the event inputs, shortened timers
`timescale 1ns/100ps

module test_challenge_count_blinker;
   localparam int unsigned WIN = 40;              // Shortened window
   localparam int unsigned FL  = 5;               // Shortened flash
   typedef struct {int n; logic sb; logic [1:0] st; logic win; logic lt;} ccb_row_t;
   ccb_row_t   rows [6] = '{'{0,1,0,0,0}, '{1,1,1,1,0}, '{2,1,2,1,0},
                            '{3,1,3,1,1}, '{4,1,3,1,1}, '{3,0,0,0,0}};
   logic       clk = 1'h0, rst_b = 1'h0, standby = 1'h1, trig, key;
   logic       light, win_sw, flash_on, clr;
   logic [1:0] state, cause;
   int         bad_count = 0, check_count = 0, n;
   ccb_blinker #(.WINDOW_CYCLES(WIN), .FLASH_CYCLES(FL)) dut (.clk(clk), .rst_b(rst_b),
      .standby(standby), .correct_challenge_trigger(trig), .challenge_keying_delay(key),
      .blinker_light(light), .window_switch(win_sw), .blink_state(state),
      .flash_running(flash_on), .clearout_pulse(clr), .clearout_cause(cause));
   ccb_partner u_far (.clk(clk), .trig(trig), .key(key));
   always #25 clk = ~clk;
   // Compare and count
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   // Cycles until the next clearout, bounded
   task automatic wait_clr(output int cnt);
      cnt = 0;
      while (clr !== 1'h1 && cnt < 200) begin
         @(negedge clk);
         cnt++;
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      chk("reset state", 0, {light, win_sw, state, flash_on, clr});
      rst_b <= 1'h1;
      foreach (rows[i]) begin
         u_far.tx(1'h0);
         @(posedge clk);
         standby <= rows[i].sb;
         u_far.rx(rows[i].n);
         @(negedge clk);
         chk("state", rows[i].st, state);
         chk("window", rows[i].win, win_sw);
         chk("light", rows[i].lt, light);
      end
      $display("test table done");
      @(posedge clk);
      standby <= 1'h1;
      u_far.tx(1'h0);
      u_far.rx(3);
      wait_clr(n);
      chk("flash cycles", FL + 2, n);
      chk("flash cause", 2, cause);
      chk("flash state", 0, {state, light});
      $display("test flash done");
      repeat (2) begin
         u_far.rx(2);
         wait_clr(n);
         chk("window cycles", WIN + 1, n);
         chk("window cause", 3, cause);
         chk("window off", 0, {win_sw, light});
      end
      $display("test window done");
      // Own challenge clears a lit blinker, then wins over a same-cycle count
      for (int j = 0; j < 2; j++) begin
         u_far.rx(3 - j);
         u_far.tx(j[0]);
         @(negedge clk);
         chk("tx clear", 7'h50, {clr, cause, state, light, win_sw});
         @(negedge clk);
         chk("tx pulse once", 0, clr);
      end
      $display("test own challenge done");
      tally_and_finish();
   end
endmodule
